// file: mss_pkg.sv
// Constants for the sequence-step configuration block of converter A.
// Assumes a 32-bit APB host; register indices are word indices.
package mss_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [7:0]  STEP5_IDX     = 8'h95;
	localparam logic [7:0]  STEP6_IDX     = 8'h96;
	localparam logic [7:0]  RESULT5_IDX   = 8'hC5;
	localparam logic [7:0]  RESULT6_IDX   = 8'hC6;
	localparam logic [7:0]  STATUS_IDX    = 8'hC7;

	// Reset values of the two step registers.
	localparam logic [15:0] STEP5_RESET   = 16'h0005;
	localparam logic [15:0] STEP6_RESET   = 16'h0006;

	// Field positions inside a step register.
	localparam int          EN_BIT        = 15;
	localparam int          GAIN_HI       = 14;
	localparam int          GAIN_LO       = 13;
	localparam int          RSVD_HI       = 12;
	localparam int          RSVD_LO       = 5;
	localparam int          NEG_BIT       = 4;
	localparam int          POS_HI        = 3;
	localparam int          POS_LO        = 0;

	// Writable bits; the reserved field never stores a one.
	localparam logic [15:0] STEP_WR_MASK  = 16'hE01F;

	// Positive codes at or above this pick an internal source.
	localparam logic [3:0]  POS_TEMP      = 4'h8;
	localparam logic [3:0]  POS_SHORT     = 4'h9;
	localparam logic [3:0]  POS_TESTDAC   = 4'hA;

	// Negative routing codes seen by the analog front end.
	localparam logic [1:0]  NEG_GROUND    = 2'h0;
	localparam logic [1:0]  NEG_INPUT7    = 2'h1;
	localparam logic [1:0]  NEG_AUTO      = 2'h2;

	// Gain multipliers.
	localparam logic [2:0]  GAIN_X1       = 3'h1;
	localparam logic [2:0]  GAIN_X2       = 3'h2;
	localparam logic [2:0]  GAIN_X4       = 3'h4;

	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_CONV = 1'b1
	} mss_state_t;

endpackage

// file: mss_step_cfg.sv
// Step 5 and step 6 configuration of the converter A sequencer, with an
// APB slave for the registers and a small step walker that skips steps.
// Assumes an APB master on ref_clk and a converter that pulses done.
//
// Functional notes
// - Bit 15 enables or disables the step.
// - Gain codes give 1, 2, 4, 4.
// - Bits 12 to 5 always read zero.
// - Bit 4 picks ground or input seven.
// - Positive codes 0 to 7 pick inputs.
// - Codes 8 and up pick internal sources.
// - Internal sources ignore the negative select bit.
`timescale 1ns/10ps
module mss_step_cfg
(
	input  logic        ref_clk,
	input  logic        nrst,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic        seq_start,
	input  logic        conv_done,
	input  logic [15:0] conv_result,
	output logic        conv_req_q,
	output logic        conv_step_q,
	output logic [2:0]  conv_gain_q,
	output logic [3:0]  conv_pos_q,
	output logic [1:0]  conv_neg_q,
	output logic        conv_internal_q,
	output logic        seq_busy
);
	import mss_pkg::*;

	logic [15:0] cfg_q [2];
	logic [15:0] result_q [2];
	logic        last_step_q;
	logic        none_q;
	mss_state_t  state_q;
	logic        en     [2];
	logic [2:0]  gain   [2];
	logic [3:0]  pos    [2];
	logic [1:0]  neg    [2];
	logic        intsrc [2];
	logic [7:0]  idx;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic        pick_ok;
	logic        pick;
	logic        pref;

	// One decoder per step keeps the two steps identical by construction.
	for (genvar i = 0; i < 2; i++)
	begin : g_dec
		mss_step_decode u_dec (
			.cfg          (cfg_q[i]),
			.step_en      (en[i]),
			.gain_mult    (gain[i]),
			.pos_sel      (pos[i]),
			.neg_route    (neg[i]),
			.internal_src (intsrc[i])
		);
	end

	// Zero-wait slave; unmapped words answer with an error, no effect.
	assign idx     = paddr[9:2];
	assign mapped  = (idx == STEP5_IDX) || (idx == STEP6_IDX) ||
	                 (idx == RESULT5_IDX) || (idx == RESULT6_IDX) ||
	                 (idx == STATUS_IDX);
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;

	// Reads are muxed from flip-flops; the reserved field is never stored.
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_acc)
		begin
			unique case (idx)
				STEP5_IDX:   prdata = {16'h0000, cfg_q[0]};
				STEP6_IDX:   prdata = {16'h0000, cfg_q[1]};
				RESULT5_IDX: prdata = {16'h0000, result_q[0]};
				RESULT6_IDX: prdata = {16'h0000, result_q[1]};
				STATUS_IDX:  prdata = {29'h0000_0000, none_q,
				                       last_step_q, state_q};
				default:     prdata = 32'h0000_0000;
			endcase
		end
	end

	// Step registers; the mask drops writes into bits 12 to 5.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q[0] <= STEP5_RESET;
			cfg_q[1] <= STEP6_RESET;
		end
		else if (wr_acc && idx == STEP5_IDX)
			cfg_q[0] <= pwdata[15:0] & STEP_WR_MASK;
		else if (wr_acc && idx == STEP6_IDX)
			cfg_q[1] <= pwdata[15:0] & STEP_WR_MASK;
	end

	// Round robin from the step after the last one converted.
	assign pref    = ~last_step_q;
	assign pick_ok = en[0] | en[1];
	assign pick    = en[pref] ? pref : ~pref;
	assign seq_busy = (state_q == SEQ_CONV);

	// Walker: a start with no enabled step only sets none_q and changes nothing else.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q     <= SEQ_IDLE;
			last_step_q <= 1'b1;
			none_q      <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				SEQ_IDLE:
				begin
					if (seq_start)
					begin
						none_q <= ~pick_ok;
						if (pick_ok)
						begin
							state_q     <= SEQ_CONV;
							last_step_q <= pick;
						end
					end
				end
				SEQ_CONV:
				begin
					if (conv_done)
						state_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	// Selections are latched at issue so a register write mid-conversion
	// cannot disturb the front end until the next step.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			conv_req_q      <= 1'b0;
			conv_step_q     <= 1'b0;
			conv_gain_q     <= GAIN_X1;
			conv_pos_q      <= 4'h0;
			conv_neg_q      <= NEG_GROUND;
			conv_internal_q <= 1'b0;
		end
		else
		begin
			conv_req_q <= 1'b0;
			if (state_q == SEQ_IDLE && seq_start && pick_ok)
			begin
				conv_req_q      <= 1'b1;
				conv_step_q     <= pick;
				conv_gain_q     <= gain[pick];
				conv_pos_q      <= pos[pick];
				conv_neg_q      <= neg[pick];
				conv_internal_q <= intsrc[pick];
			end
		end
	end

	// Only the step that was converted has its result updated.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			result_q[0] <= 16'h0000;
			result_q[1] <= 16'h0000;
		end
		else if (state_q == SEQ_CONV && conv_done)
			result_q[last_step_q] <= conv_result;
	end

	chk_reserved_reads_zero: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		rd_acc && (idx == STEP5_IDX || idx == STEP6_IDX)
		|-> prdata[RSVD_HI:RSVD_LO] == 8'h00)
		else $error("Reserved step bits read nonzero.");

	chk_write_stores_cfg: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		wr_acc && idx == STEP5_IDX
		|=> cfg_q[0] == ($past(pwdata[15:0]) & STEP_WR_MASK))
		else $error("Step 5 write not stored.");

	chk_issue_enabled_only: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		conv_req_q |-> (conv_step_q ? $past(en[1]) : $past(en[0])))
		else $error("Disabled step was issued.");

	chk_skip_disabled: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == SEQ_IDLE && seq_start && !en[0] && !en[1]
		|=> !conv_req_q && state_q == SEQ_IDLE && none_q)
		else $error("Start with no enabled step did something.");

	chk_gain_map: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == SEQ_IDLE && seq_start && pick_ok
		|=> conv_gain_q == (($past(cfg_q[pick][GAIN_HI:GAIN_LO]) == 2'b00)
		    ? GAIN_X1 : ($past(cfg_q[pick][GAIN_HI:GAIN_LO]) == 2'b01)
		    ? GAIN_X2 : GAIN_X4))
		else $error("Gain code decoded wrongly.");

	chk_auto_negative: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		conv_req_q && conv_pos_q >= POS_TEMP
		|-> conv_neg_q == NEG_AUTO && conv_internal_q)
		else $error("Internal source used the negative select bit.");

	chk_external_route: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == SEQ_IDLE && seq_start && pick_ok &&
		!pos[pick][POS_HI]
		|=> conv_neg_q == {1'b0, $past(cfg_q[pick][NEG_BIT])}
		    && !conv_internal_q)
		else $error("External step negative route wrong.");

	chk_result_only_done: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		!(state_q == SEQ_CONV && conv_done)
		|=> $stable(result_q[0]) && $stable(result_q[1]))
		else $error("Result changed without a conversion.");

	chk_unmapped_error: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		psel && penable && !mapped |-> pslverr && pready)
		else $error("Unmapped access not flagged.");

endmodule

// file: mss_step_cfg_tb.sv
// Self-checking bench for the step configuration block of converter A.
// Assumes a zero-wait APB slave and a walker answering one cycle late.
`timescale 1ns/10ps
module mss_step_cfg_tb;
	import mss_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end end
	logic        ref_clk = 0;
	logic        nrst = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        seq_start = 0;
	logic        conv_done = 0;
	logic [15:0] conv_result = 0;
	logic        conv_req_q;
	logic        conv_step_q;
	logic [2:0]  conv_gain_q;
	logic [3:0]  conv_pos_q;
	logic [1:0]  conv_neg_q;
	logic        conv_internal_q;
	logic        seq_busy;
	int          error_cnt = 0;
	int          total_checks = 0;
	// Rows: written word, then expected gain, negative route, internal.
	logic [15:0] cfg_tab [6] = '{16'h9FE3, 16'hA017, 16'hC018,
		16'hE009, 16'h801F, 16'h8010};
	logic [5:0]  exp_tab [6] = '{6'h08, 6'h12, 6'h25, 6'h25, 6'h0D, 6'h0A};

	mss_step_cfg dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .seq_start(seq_start), .conv_done(conv_done),
		.conv_result(conv_result), .conv_req_q(conv_req_q),
		.conv_step_q(conv_step_q), .conv_gain_q(conv_gain_q),
		.conv_pos_q(conv_pos_q), .conv_neg_q(conv_neg_q),
		.conv_internal_q(conv_internal_q), .seq_busy(seq_busy));

	// Free-running 20 MHz clock.
	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end

	task conclude;
		$display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One APB transfer; the wait is bounded so a dead slave cannot hang us.
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 20)
		begin
			error_cnt++;
			conclude();
		end
	endtask

	// Pulse start; the issue pulse stands in the following cycle.
	task start;
		@(posedge ref_clk);
		seq_start <= 1;
		@(posedge ref_clk);
		seq_start <= 0;
		#1;
	endtask

	// Converter answer; busy must drop after the done edge.
	task done(input logic [15:0] r);
		@(posedge ref_clk);
		conv_done <= 1;
		conv_result <= r;
		@(posedge ref_clk);
		conv_done <= 0;
		#1;
		`CHK("busy", 1'b0, seq_busy)
	endtask

	initial
	begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1;
		apb(0, STEP5_IDX, 0);
		`CHK("step5 reset", 32'h0000_0005, rd)
		apb(0, STEP6_IDX, 0);
		`CHK("step6 reset", 32'h0000_0006, rd)
		apb(0, STATUS_IDX, 0);
		`CHK("status reset", 32'h0000_0002, rd)
		// Step 6 stays disabled, so every start issues step 5.
		for (int n = 0; n < 6; n++)
		begin
			apb(1, STEP5_IDX, {16'hFFFF, cfg_tab[n]});
			apb(0, STEP5_IDX, 0);
			`CHK("readback", {16'h0000, cfg_tab[n] & 16'hE01F}, rd)
			start();
			`CHK("issue", 1'b1, conv_req_q)
			`CHK("busy high", 1'b1, seq_busy)
			`CHK("step", 1'b0, conv_step_q)
			`CHK("gain", exp_tab[n][5:3], conv_gain_q)
			`CHK("pos", cfg_tab[n][3:0], conv_pos_q)
			`CHK("neg", exp_tab[n][2:1], conv_neg_q)
			`CHK("internal", exp_tab[n][0], conv_internal_q)
			done(16'h00A0 + 16'(n));
			apb(0, RESULT5_IDX, 0);
			`CHK("result5", 32'h0000_00A0 + 32'(n), rd)
		end
		$display("Row tests done");
		// Only step 6 enabled: step 5 is skipped and its result kept.
		apb(1, STEP5_IDX, 0);
		apb(1, STEP6_IDX, 32'h0000_8006);
		start();
		`CHK("skip step", 1'b1, conv_step_q)
		`CHK("pos6", 4'h6, conv_pos_q)
		done(16'h1234);
		apb(0, RESULT6_IDX, 0);
		`CHK("result6", 32'h0000_1234, rd)
		apb(0, RESULT5_IDX, 0);
		`CHK("result5 kept", 32'h0000_00A5, rd)
		// Nothing enabled: no issue, status flags it.
		apb(1, STEP6_IDX, 0);
		start();
		`CHK("no issue", 1'b0, conv_req_q)
		apb(0, STATUS_IDX, 0);
		`CHK("status", 3'h6, rd[2:0])
		$display("Skip tests done");
		// Unmapped word refuses the access.
		apb(0, 8'h00, 0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0000_0000, rd)
		apb(1, 8'h00, 32'hFFFF_FFFF);
		`CHK("unmapped wr err", 1'b1, err)
		// A second reset in mid-run restores the step 5 register.
		apb(1, STEP5_IDX, 32'h0000_A017);
		@(posedge ref_clk);
		nrst <= 0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		apb(0, STEP5_IDX, 0);
		`CHK("step5 rereset", 32'h0000_0005, rd)
		$display("Reset tests done");
		conclude();
	end
endmodule

// file: mss_step_decode.sv
// Decodes one step configuration word into analog front-end selections.
// Assumes the word comes straight from a register flip-flop.
`timescale 1ns/10ps
module mss_step_decode
(
	input  logic [15:0] cfg,
	output logic        step_en,
	output logic [2:0]  gain_mult,
	output logic [3:0]  pos_sel,
	output logic [1:0]  neg_route,
	output logic        internal_src
);
	import mss_pkg::*;

	// Enable, positive routing and the internal flag are plain field decodes.
	assign step_en      = cfg[EN_BIT];
	assign pos_sel      = cfg[POS_HI:POS_LO];
	assign internal_src = cfg[POS_HI];

	// Codes 10 and 11 both give gain four.
	always_comb
	begin
		unique case (cfg[GAIN_HI:GAIN_LO])
			2'b00:   gain_mult = GAIN_X1;
			2'b01:   gain_mult = GAIN_X2;
			default: gain_mult = GAIN_X4;
		endcase
	end

	// Internal sources pick their own negative input, so bit 4 is moot.
	always_comb
	begin
		if (cfg[POS_HI])
			neg_route = NEG_AUTO;
		else if (cfg[NEG_BIT])
			neg_route = NEG_INPUT7;
		else
			neg_route = NEG_GROUND;
	end

endmodule
